// ### design/pser_pkg.sv
/*
  Shared constants and carriers of the paged status and event register bank:
  register addresses, field layout, page codes and timing counts.
  Assumes a single 40 MHz system clock.
*/
package pser_pkg;
  localparam int          CLK_MHZ         = 40;
  localparam logic [6:0]  PAGE_CTRL_LOW   = 7'h00;
  localparam logic [8:0]  ADDR_ST_INPUT   = 9'h050;
  localparam logic [8:0]  ADDR_ST_REG     = 9'h051;
  localparam logic [8:0]  ADDR_EV_INPUT   = 9'h052;
  localparam logic [8:0]  ADDR_EV_REG     = 9'h053;
  localparam logic [8:0]  ADDR_MK_INPUT   = 9'h054;
  localparam logic [8:0]  ADDR_MK_REG     = 9'h055;
  localparam logic [8:0]  ADDR_CTRL_A     = 9'h056;
  localparam logic [8:0]  LOCK_LO         = 9'h0D0;
  localparam logic [8:0]  LOCK_HI         = 9'h14F;
  localparam int          PG_AUTO_BIT     = 7;
  localparam int          PG_WMODE_BIT    = 6;
  localparam int          CA_LOCK_BIT     = 5;
  localparam int          CA_SLEW_LSB     = 3;
  localparam logic [2:0]  PAGE_0          = 3'h0;
  localparam logic [2:0]  PAGE_1          = 3'h1;
  localparam logic [2:0]  PAGE_2          = 3'h2;
  localparam logic [7:0]  INPUT_MASK      = 8'h7F;
  localparam logic [7:0]  REG_MASK        = 8'h1F;
  localparam logic [7:0]  CTRL_A_MASK     = 8'h3F;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam int          RAMP_STEP_MV    = 10;
  localparam int          SLEW_T0_NS      = 4000;
  localparam int          SLEW_T1_NS      = 2000;
  localparam int          SLEW_T2_NS      = 1000;
  localparam int          SLEW_T3_NS      = 500;
  localparam logic [7:0]  SLEW_C0 = 8'(SLEW_T0_NS * CLK_MHZ / 1000);
  localparam logic [7:0]  SLEW_C1 = 8'(SLEW_T1_NS * CLK_MHZ / 1000);
  localparam logic [7:0]  SLEW_C2 = 8'(SLEW_T2_NS * CLK_MHZ / 1000);
  localparam logic [7:0]  SLEW_C3 = 8'(SLEW_T3_NS * CLK_MHZ / 1000);
  // debounce times in units of 100 us
  localparam int          DEB_TICK_NS     = 100000;
  localparam int          DEB_TICK_CYC    = DEB_TICK_NS * CLK_MHZ / 1000;
  localparam logic [13:0] DEB_T1          = 14'h0001;
  localparam logic [13:0] DEB_T2          = 14'h000A;
  localparam logic [13:0] DEB_T3          = 14'h0064;
  localparam logic [13:0] DEB_T4          = 14'h01F4;
  localparam logic [13:0] DEB_T5          = 14'h09C4;
  localparam logic [13:0] DEB_T6          = 14'h1388;
  localparam logic [13:0] DEB_T7          = 14'h2710;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       first;
    logic       done;
    logic [7:0] offset;
    logic [7:0] wdata;
  } pser_acc_s;

  typedef struct packed {
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
    logic output_out_of_range_flag;
    logic overcurrent_flag;
  } pser_cond_s;
endpackage

// ### design/pser_debounce.sv
/*
  Per-pin debounce filter for the seven general inputs.
  Assumes inputs already synchronous to CLK.
*/
`timescale 1ns/1ps
module pser_debounce #(
  parameter int TICK_CYCLES = pser_pkg::DEB_TICK_CYC
) (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic [6:0] RAW,
  input  wire logic [6:0] EN,
  input  wire logic [2:0] CODE,
  output logic      [6:0] FILT
);
  logic [15:0] pre_reg;
  logic        tick;
  logic [13:0] cnt_reg [7];
  logic [13:0] limit;

  function automatic logic [13:0] deb_ticks(input logic [2:0] c);
    case (c)
      3'h1:    deb_ticks = pser_pkg::DEB_T1;
      3'h2:    deb_ticks = pser_pkg::DEB_T2;
      3'h3:    deb_ticks = pser_pkg::DEB_T3;
      3'h4:    deb_ticks = pser_pkg::DEB_T4;
      3'h5:    deb_ticks = pser_pkg::DEB_T5;
      3'h6:    deb_ticks = pser_pkg::DEB_T6;
      default: deb_ticks = pser_pkg::DEB_T7;
    endcase
  endfunction

  assign tick  = (pre_reg == 16'(TICK_CYCLES - 1));
  assign limit = deb_ticks(CODE);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pre_reg <= 16'h0000;
    end else if (tick) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
    end
  end

  for (genvar i = 0; i < 7; i++) begin : g_pin
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        cnt_reg[i] <= 14'h0000;
        FILT[i]    <= 1'b0;
      end else if (!EN[i] || CODE == 3'h0) begin
        cnt_reg[i] <= 14'h0000;
        FILT[i]    <= RAW[i];
      end else if (RAW[i] == FILT[i]) begin
        cnt_reg[i] <= 14'h0000;
      end else if (tick) begin
        if (cnt_reg[i] + 14'h0001 >= limit) begin
          cnt_reg[i] <= 14'h0000;
          FILT[i]    <= RAW[i];
        end else begin
          cnt_reg[i] <= cnt_reg[i] + 14'h0001;
        end
      end
    end
  end
endmodule

// ### design/pser_ramp.sv
/*
  Ramp interval timer: one pulse per voltage step interval.
  Assumes the 40 MHz system clock.
*/
`timescale 1ns/1ps
module pser_ramp (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic [1:0] CODE,
  output logic            TICK
);
  logic [7:0] cnt_reg;
  logic [7:0] limit;

  always_comb begin
    case (CODE)
      2'h0:    limit = pser_pkg::SLEW_C0;
      2'h1:    limit = pser_pkg::SLEW_C1;
      2'h2:    limit = pser_pkg::SLEW_C2;
      default: limit = pser_pkg::SLEW_C3;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_reg <= 8'h00;
      TICK    <= 1'b0;
    end else if (cnt_reg + 8'h01 >= limit) begin
      cnt_reg <= 8'h00;
      TICK    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      TICK    <= 1'b0;
    end
  end
endmodule

// ### design/pser_top.sv
/*
  Paged register bank: page control, live status, event latches, masks,
  interrupt and alarm port, write lock, ramp and debounce codes.
  Assumes a serial front end that delivers byte accesses as pser_acc_s
  and serves registers outside this bank via the EXT_* signals.
*/
`timescale 1ns/1ps
module pser_top #(
  parameter int DEBOUNCE_TICK_CYCLES = pser_pkg::DEB_TICK_CYC
) (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire pser_pkg::pser_acc_s  ACC,
  input  wire logic                 FOUR_WIRE_IF,
  input  wire logic [7:0]           EXT_RDATA,
  input  wire logic [6:0]           GENERAL_INPUT,
  input  wire logic [6:0]           PIN_ACTIVE_LEVEL,
  input  wire logic [6:0]           DEBOUNCE_EN,
  input  wire pser_pkg::pser_cond_s COND,
  input  wire logic [6:0]           CONFIG_VOLTAGE,
  input  wire logic [6:0]           MAX_OUTPUT_VOLTAGE,
  input  wire logic                 ALARM_IRQ_MODE,
  input  wire logic                 ALARM_ACTIVE_HIGH,
  output logic      [7:0]           RDATA,
  output logic                      RDATA_VALID,
  output logic      [8:0]           REG_ADDR,
  output logic                      EXT_RD,
  output logic                      EXT_WR,
  output logic      [7:0]           EXT_WDATA,
  output logic                      INTERRUPT_OUT_N,
  output logic                      ALARM_PORT,
  output logic                      RAMP_STEP_TICK
);
  logic       page_auto_return_reg;
  logic       write_mode_reg;
  logic [2:0] page_sel_reg;
  logic [8:0] ptr_reg;
  logic       ptr_ok_reg;
  logic [6:0] ev_a_reg;
  logic [6:0] ev_a_pend_reg;
  logic [6:0] mask_a_reg;
  logic [6:0] prev_a_reg;
  logic [4:0] ev_b_reg;
  logic [4:0] ev_b_pend_reg;
  logic [4:0] mask_b_reg;
  logic [4:0] prev_b_reg;
  logic [5:0] ctrl_a_reg;
  logic       rd_pend_reg;
  logic       rd_own_reg;
  logic [6:0] gpi_filt;
  logic [9:0] mapped;
  logic [8:0] cur_addr;
  logic       cur_ok;
  logic       take;
  logic       wr_take;
  logic       own;
  logic       locked;
  logic       voltage_ceiling_flag;
  logic [7:0] st_a;
  logic [7:0] st_b;
  logic [6:0] act_a;
  logic [6:0] new_a;
  logic [4:0] new_b;
  logic       clr_a;
  logic       clr_b;
  logic       irq_any;
  logic       ded_any;
  logic [7:0] own_rdata;

  // returns {ok, address} for the first byte of a transaction
  function automatic logic [9:0] map_addr(input logic       four,
                                          input logic [2:0] page,
                                          input logic [7:0] off);
    if (!four) begin
      case (page[2:1])
        2'h0:    map_addr = {1'b1, 1'b0, off};
        2'h1:    map_addr = {1'b1, 2'h2, off[6:0]};
        default: map_addr = 10'h000;
      endcase
    end else begin
      case (page)
        pser_pkg::PAGE_0: map_addr = {1'b1, 2'h0, off[6:0]};
        pser_pkg::PAGE_1: map_addr = {1'b1, 2'h1, off[6:0]};
        pser_pkg::PAGE_2: map_addr = {1'b1, 2'h2, off[6:0]};
        default:          map_addr = 10'h000;
      endcase
    end
  endfunction

  assign take    = ACC.valid;
  assign mapped  = map_addr(FOUR_WIRE_IF, page_sel_reg, ACC.offset);

  always_comb begin
    cur_addr = ptr_reg + 9'h001;
    cur_ok   = ptr_ok_reg;
    if (ACC.first) begin
      cur_addr = mapped[8:0];
      cur_ok   = mapped[9];
    end else if (ACC.write && !FOUR_WIRE_IF && write_mode_reg) begin
      cur_addr = ptr_reg;
    end
  end

  assign wr_take = take && ACC.write && cur_ok;
  assign own     = (cur_addr[6:0] == pser_pkg::PAGE_CTRL_LOW) ||
                   (cur_addr >= pser_pkg::ADDR_ST_INPUT &&
                    cur_addr <= pser_pkg::ADDR_CTRL_A);
  assign locked  = ctrl_a_reg[pser_pkg::CA_LOCK_BIT] &&
                   cur_addr >= pser_pkg::LOCK_LO &&
                   cur_addr <= pser_pkg::LOCK_HI;

  // address pointer for consecutive bytes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ptr_reg    <= 9'h000;
      ptr_ok_reg <= 1'b0;
    end else if (take) begin
      ptr_reg    <= cur_addr;
      ptr_ok_reg <= cur_ok;
    end
  end

  // page control fields
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      page_auto_return_reg <= 1'b0;
      write_mode_reg       <= 1'b0;
    end else if (wr_take && cur_addr[6:0] == pser_pkg::PAGE_CTRL_LOW) begin
      page_auto_return_reg <= ACC.wdata[pser_pkg::PG_AUTO_BIT];
      write_mode_reg       <= ACC.wdata[pser_pkg::PG_WMODE_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      page_sel_reg <= pser_pkg::PAGE_0;
    end else if (take && ACC.done && page_auto_return_reg) begin
      page_sel_reg <= pser_pkg::PAGE_0;
    end else if (wr_take && cur_addr[6:0] == pser_pkg::PAGE_CTRL_LOW) begin
      page_sel_reg <= ACC.wdata[2:0];
    end
  end

  // masks and control byte; reserved bits are not stored
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mask_a_reg <= pser_pkg::RESET_BYTE[6:0];
      mask_b_reg <= pser_pkg::RESET_BYTE[4:0];
      ctrl_a_reg <= pser_pkg::RESET_BYTE[5:0];
    end else if (wr_take) begin
      if (cur_addr == pser_pkg::ADDR_MK_INPUT) begin
        mask_a_reg <= ACC.wdata[6:0];
      end
      if (cur_addr == pser_pkg::ADDR_MK_REG) begin
        mask_b_reg <= ACC.wdata[4:0];
      end
      if (cur_addr == pser_pkg::ADDR_CTRL_A) begin
        ctrl_a_reg <= ACC.wdata[5:0];
      end
    end
  end

  pser_debounce #(
    .TICK_CYCLES (DEBOUNCE_TICK_CYCLES)
  ) u_debounce (
    .CLK  (CLK),
    .NRST (NRST),
    .RAW  (GENERAL_INPUT),
    .EN   (DEBOUNCE_EN),
    .CODE (ctrl_a_reg[2:0]),
    .FILT (gpi_filt)
  );

  pser_ramp u_ramp (
    .CLK  (CLK),
    .NRST (NRST),
    .CODE (ctrl_a_reg[pser_pkg::CA_SLEW_LSB +: 2]),
    .TICK (RAMP_STEP_TICK)
  );

  // live status, no inversion
  assign voltage_ceiling_flag = CONFIG_VOLTAGE >= MAX_OUTPUT_VOLTAGE;
  assign st_a = {1'b0, gpi_filt};
  assign st_b = {3'h0, voltage_ceiling_flag,
                 COND.thermal_shutdown_flag, COND.thermal_warning_flag,
                 COND.output_out_of_range_flag,
                 COND.overcurrent_flag};

  // event detection
  assign act_a = ~(gpi_filt ^ PIN_ACTIVE_LEVEL);
  assign new_a = ALARM_IRQ_MODE ? (act_a ^ prev_a_reg)
                                : (act_a & ~prev_a_reg);
  assign new_b = ALARM_IRQ_MODE ? (st_b[4:0] ^ prev_b_reg)
                                : (st_b[4:0] & ~prev_b_reg);
  assign clr_a = wr_take && cur_addr == pser_pkg::ADDR_EV_INPUT;
  assign clr_b = wr_take && cur_addr == pser_pkg::ADDR_EV_REG;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prev_a_reg <= 7'h00;
      prev_b_reg <= 5'h00;
    end else begin
      prev_a_reg <= act_a;
      prev_b_reg <= st_b[4:0];
    end
  end

  // events seen during a clear wait one cycle in the pending latch
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ev_a_reg      <= 7'h00;
      ev_a_pend_reg <= 7'h00;
    end else if (clr_a) begin
      ev_a_reg      <= (ev_a_reg & ~ACC.wdata[6:0]) | ev_a_pend_reg;
      ev_a_pend_reg <= new_a;
    end else begin
      ev_a_reg      <= ev_a_reg | new_a | ev_a_pend_reg;
      ev_a_pend_reg <= 7'h00;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ev_b_reg      <= 5'h00;
      ev_b_pend_reg <= 5'h00;
    end else if (clr_b) begin
      ev_b_reg      <= (ev_b_reg & ~ACC.wdata[4:0]) | ev_b_pend_reg;
      ev_b_pend_reg <= new_b;
    end else begin
      ev_b_reg      <= ev_b_reg | new_b | ev_b_pend_reg;
      ev_b_pend_reg <= 5'h00;
    end
  end

  // interrupt and alarm port
  assign irq_any = |(ev_a_reg & ~mask_a_reg) ||
                   |(ev_b_reg & ~mask_b_reg);
  assign ded_any = |(st_b[4:0] & ~mask_b_reg);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      INTERRUPT_OUT_N <= 1'b1;
      ALARM_PORT      <= 1'b1;
    end else begin
      INTERRUPT_OUT_N <= !(ALARM_IRQ_MODE && irq_any);
      ALARM_PORT      <= ALARM_IRQ_MODE ? !irq_any
                         : (ded_any == ALARM_ACTIVE_HIGH);
    end
  end

  // access outputs
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_ADDR    <= 9'h000;
      EXT_WR      <= 1'b0;
      EXT_WDATA   <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_own_reg  <= 1'b0;
    end else begin
      if (take) begin
        REG_ADDR  <= cur_addr;
        EXT_WDATA <= ACC.wdata;
      end
      EXT_WR      <= wr_take && !own && !locked;
      rd_pend_reg <= take && !ACC.write;
      rd_own_reg  <= own && cur_ok;
    end
  end

  assign EXT_RD = rd_pend_reg && !rd_own_reg && ptr_ok_reg;

  always_comb begin
    own_rdata = 8'h00;
    if (REG_ADDR[6:0] == pser_pkg::PAGE_CTRL_LOW) begin
      own_rdata = {page_auto_return_reg, write_mode_reg, 3'h0, page_sel_reg};
    end else begin
      case (REG_ADDR)
        pser_pkg::ADDR_ST_INPUT: own_rdata = st_a & pser_pkg::INPUT_MASK;
        pser_pkg::ADDR_ST_REG:   own_rdata = st_b & pser_pkg::REG_MASK;
        pser_pkg::ADDR_EV_INPUT: own_rdata = {1'b0, ev_a_reg};
        pser_pkg::ADDR_EV_REG:   own_rdata = {3'h0, ev_b_reg};
        pser_pkg::ADDR_MK_INPUT: own_rdata = {1'b0, mask_a_reg};
        pser_pkg::ADDR_MK_REG:   own_rdata = {3'h0, mask_b_reg};
        pser_pkg::ADDR_CTRL_A:   own_rdata = {2'h0, ctrl_a_reg};
        default:                 own_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA       <= 8'h00;
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= rd_pend_reg;
      if (rd_pend_reg) begin
        RDATA <= !ptr_ok_reg ? 8'h00 : rd_own_reg ? own_rdata : EXT_RDATA;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_auto_return;
    take && ACC.done && page_auto_return_reg |=> page_sel_reg == 3'h0;
  endproperty
  a_auto_return: assert property (p_auto_return)
    else $error("page not returned after access");

  property p_repeat;
    take && ACC.write && !ACC.first && !FOUR_WIRE_IF && write_mode_reg
      |=> REG_ADDR == $past(ptr_reg);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeated write moved address");

  property p_four_incr;
    take && !ACC.first && FOUR_WIRE_IF |=> REG_ADDR == $past(ptr_reg) + 9'h001;
  endproperty
  a_four_incr: assert property (p_four_incr)
    else $error("four-wire burst did not increment");

  property p_map_page1;
    take && ACC.first && FOUR_WIRE_IF && page_sel_reg == 3'h1
      |=> REG_ADDR == {2'h1, $past(ACC.offset[6:0])};
  endproperty
  a_map_page1: assert property (p_map_page1)
    else $error("four-wire page 1 mapped wrong");

  property p_status_read;
    rd_pend_reg && rd_own_reg && REG_ADDR == 9'h051
      |=> RDATA == $past(st_b);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read not live");

  property p_irq;
    ALARM_IRQ_MODE && irq_any |=> !INTERRUPT_OUT_N;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not asserted");

  property p_clear;
    clr_a && ev_a_pend_reg == 7'h00 && new_a == 7'h00
      |=> (ev_a_reg & $past(ACC.wdata[6:0])) == 7'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("event not cleared");

  property p_held;
    clr_b && new_b != 5'h00 ##1 !clr_b
      |=> (ev_b_reg & $past(new_b, 2)) == $past(new_b, 2);
  endproperty
  a_held: assert property (p_held)
    else $error("event lost during clear");

  property p_lock;
    wr_take && locked |=> !EXT_WR;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write passed");

  c_auto_return: cover property (take && ACC.done && page_auto_return_reg);
  c_held:        cover property (clr_a && new_a != 7'h00);
  c_irq:         cover property ($fell(INTERRUPT_OUT_N));
  c_lock:        cover property (wr_take && locked);
endmodule

// ### verification/pser_host.sv
/*
  Host model: issues single byte accesses to the register bank.
  Assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/1ps
module pser_host (
  input  wire logic    CLK,
  output pser_pkg::pser_acc_s ACC
);
  initial ACC = '0;

  // one byte, held from a falling edge across one sampling edge
  // page codes above 2 are never issued on the four-wire link
  task automatic xfer(input logic w, input logic f, input logic d,
                      input logic [7:0] off, input logic [7:0] wd);
    @(negedge CLK);
    ACC = {1'b1, w, f, d, off, wd};
    @(negedge CLK);
    ACC = '0;
  endtask
endmodule

// ### verification/tb.sv
/*
  Self-checking bench for the paged register bank.
  Assumes pser_host drives accesses; external registers answer ext_val.
*/
`timescale 1ns/1ps
module tb;
  logic                 clk      = 1'b0;
  logic                 nrst     = 1'b0;
  pser_pkg::pser_acc_s  acc;
  pser_pkg::pser_cond_s cond     = '0;
  logic                 fw       = 1'b0;
  logic                 irq_mode = 1'b1;
  logic                 act_high = 1'b1;
  logic [7:0]           ext_val  = 8'h00;
  logic [6:0]           gi       = 7'h00;
  logic [6:0]           g_old;
  logic [6:0]           pal      = 7'h00;
  logic [6:0]           deb_en   = 7'h00;
  logic [6:0]           cfg_v    = 7'h0F;
  logic [6:0]           max_v    = 7'h10;
  logic [7:0]           rdata;
  logic [7:0]           ext_wdata;
  logic [8:0]           reg_addr;
  logic                 rvalid, ext_wr, ext_rd, irq_n, alarm, tick;
  logic [7:0]           exp_q[$];
  int                   fail_count = 0;
  int                   compares   = 0;
  int                   wr_cnt     = 0;
  int                   n;

  always #12.5 clk = ~clk;

  pser_host host_u (.CLK(clk), .ACC(acc));
  pser_top #(.DEBOUNCE_TICK_CYCLES(4)) dut_u (
    .CLK(clk), .NRST(nrst), .ACC(acc), .FOUR_WIRE_IF(fw),
    .EXT_RDATA(ext_val), .GENERAL_INPUT(gi), .PIN_ACTIVE_LEVEL(pal),
    .DEBOUNCE_EN(deb_en), .COND(cond), .CONFIG_VOLTAGE(cfg_v),
    .MAX_OUTPUT_VOLTAGE(max_v), .ALARM_IRQ_MODE(irq_mode),
    .ALARM_ACTIVE_HIGH(act_high), .RDATA(rdata), .RDATA_VALID(rvalid),
    .REG_ADDR(reg_addr), .EXT_RD(ext_rd), .EXT_WR(ext_wr),
    .EXT_WDATA(ext_wdata), .INTERRUPT_OUT_N(irq_n), .ALARM_PORT(alarm),
    .RAMP_STEP_TICK(tick));

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    host_u.xfer(1'b1, 1'b1, 1'b1, off, d);
  endtask

  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, 1'b1, 1'b1, off, 8'h00);
  endtask

  task automatic wait_tick();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 400);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // read data checked against the oldest noted expectation
  always @(posedge clk) begin
    if (ext_wr === 1'b1) wr_cnt <= wr_cnt + 1;
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(9'(rdata), 9'h1FF);
      else chk(9'(rdata), 9'(exp_q.pop_front()));
    end
  end

  initial begin
    #(25 * 8000);
    fail_count++;
    results();
  end

  initial begin
    void'($urandom(32'h30169bb7));
    ext_val = 8'($urandom);
    pal = 7'($urandom);
    deb_en = 7'($urandom);
    max_v = 7'($urandom) | 7'h01;
    cfg_v = max_v - 7'h01;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    wr(8'h54, 8'hFF);
    rd(8'h54, 8'h7F);
    wr(8'h54, 8'h00);
    wr(8'h52, 8'hFF);
    wr(8'h53, 8'hFF);
    g_old = gi;
    gi = 7'($urandom);
    cond = 4'($urandom);
    cfg_v = max_v;
    repeat (3) @(negedge clk);
    rd(8'h50, {1'b0, gi});
    rd(8'h51, {3'h0, 1'b1, cond});
    rd(8'h52, {1'b0, gi ^ g_old});
    rd(8'h53, {3'h0, 1'b1, cond});
    chk(9'(irq_n), 9'h0);
    chk(9'(alarm), 9'h0);
    wr(8'h52, {1'b0, gi ^ g_old});
    wr(8'h53, {3'h0, 1'b1, cond});
    repeat (2) @(negedge clk);
    chk(9'(irq_n), 9'h1);
    cfg_v = max_v - 7'h01;
    repeat (3) @(negedge clk);
    // new event lands in the same cycle as its neighbour's clear
    fork
      wr(8'h53, 8'h10);
      begin
        @(negedge clk);
        cond[0] = ~cond[0];
      end
    join
    repeat (2) @(negedge clk);
    rd(8'h53, 8'h01);
    wr(8'h53, 8'h01);
    wr(8'h55, 8'h1F);
    cond[1] = ~cond[1];
    repeat (3) @(negedge clk);
    chk(9'(irq_n), 9'h1);
    rd(8'h53, 8'h02);
    wr(8'h55, 8'h00);
    repeat (2) @(negedge clk);
    chk(9'(irq_n), 9'h0);
    cond = '0;
    repeat (3) @(negedge clk);
    wr(8'h53, 8'h1F);
    irq_mode = 1'b0;
    repeat (3) @(negedge clk);
    chk(9'(alarm), 9'h0);
    chk(9'(irq_n), 9'h1);
    cond[3] = 1'b1;
    repeat (3) @(negedge clk);
    chk(9'(alarm), 9'h1);
    cond[3] = 1'b0;
    act_high = 1'b0;
    repeat (3) @(negedge clk);
    chk(9'(alarm), 9'h1);
    rd(8'h53, 8'h08);
    irq_mode = 1'b1;
    act_high = 1'b1;
    fw = 1'b1;
    for (int p = 0; p < 3; p++) begin
      wr(8'h00, 8'(p));
      rd(8'h5D, ext_val);
      chk(9'(ext_rd), 9'h1);
      chk(reg_addr, {p[1:0], 7'h5D});
    end
    wr(8'h00, 8'h00);
    fw = 1'b0;
    host_u.xfer(1'b1, 1'b1, 1'b0, 8'h00, 8'h82);
    rd(8'h50, ext_val);
    chk(reg_addr, 9'h150);
    rd(8'h50, {1'b0, gi});
    chk(reg_addr, 9'h050);
    chk(9'(ext_rd), 9'h0);
    for (int f = 0; f < 2; f++) begin
      fw = f[0];
      wr(8'h00, 8'h40);
      host_u.xfer(1'b1, 1'b1, 1'b0, 8'h54, 8'h11);
      host_u.xfer(1'b1, 1'b0, 1'b1, 8'h00, 8'h22);
      chk(reg_addr, 9'h054 + 9'(f));
      rd(8'h54, f ? 8'h11 : 8'h22);
    end
    fw = 1'b0;
    wr(8'h56, 8'h20);
    wr(8'h00, 8'h01);
    n = wr_cnt;
    wr(8'hD0, 8'h5A);
    @(negedge clk);
    chk(9'(wr_cnt - n), 9'h0);
    wr(8'h56, 8'h00);
    wr(8'hD0, 8'hA5);
    @(negedge clk);
    chk(9'(wr_cnt - n), 9'h1);
    chk(9'(ext_wdata), 9'h0A5);
    wr(8'h00, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h56, 8'(c << 3));
      wait_tick();
      wait_tick();
      chk(9'(n), 9'(160 >> c));
    end
    // dedicated mode: input events only on activation at pin level
    wr(8'h52, 8'h7F);
    irq_mode = 1'b0;
    g_old = gi;
    gi = ~gi;
    repeat (3) @(negedge clk);
    rd(8'h52, {1'b0, ~(gi ^ pal)});
    irq_mode = 1'b1;
    // debounce code 2: filtered pins lag, unfiltered follow at once
    wr(8'h56, 8'h02);
    g_old = gi;
    gi = ~gi;
    rd(8'h50, {1'b0, (gi & ~deb_en) | (g_old & deb_en)});
    repeat (50) @(negedge clk);
    rd(8'h50, {1'b0, gi});
    repeat (4) @(negedge clk);
    results();
  end
endmodule
